// *** inc/upload_pkg.sv ***
// constants and types for the receive upload engine
package upload_pkg;
    // register offsets
    localparam logic [7:0]  OFS_STATUS     = 8'h30;
    localparam logic [7:0]  OFS_PTR        = 8'h38;
    localparam logic [7:0]  OFS_THRESH     = 8'h40;
    localparam logic [7:0]  OFS_CMD        = 8'h44;
    localparam logic [7:0]  OFS_POLL       = 8'h48;
    // reset values
    localparam logic [7:0]  THRESH_RST     = 8'h04;
    localparam logic [7:0]  POLL_RST       = 8'h00;
    // command register bits
    localparam int          CMD_PAUSE      = 0;
    localparam int          CMD_RESUME     = 1;
    localparam int          CMD_UP_RST     = 2;
    localparam int          CMD_ALL_RST    = 3;
    // packet status fields
    localparam int          LEN_W          = 15;
    localparam int          INFO_W         = 7;
    localparam int          ST_PAUSED      = 15;
    localparam int          ST_COMPLETE    = 23;
    localparam int          ST_NEEDED      = 24;
    localparam int          ST_FULL        = 25;
    // descriptor layout
    localparam logic [31:0] DESC_LINK      = 32'h0000_0000;
    localparam logic [31:0] DESC_STAT      = 32'h0000_0004;
    localparam logic [31:0] DESC_FRAG      = 32'h0000_0008;
    localparam int          FRAG_LAST      = 31;
    localparam int          FRAG_LEN_W     = 16;
    localparam logic [31:0] PTR_MASK       = 32'hffff_fff8;
    localparam logic [15:0] WORD_BYTES     = 16'h0004;
    // frame visibility and burst unit
    localparam logic [15:0] VISIBLE_BYTES  = 16'h0040;
    localparam int          BURST_UNIT_SH  = 5;
    // poll interval unit
    localparam int          CLK_MHZ        = 20;
    localparam int          POLL_UNIT_NS   = 320;
    localparam logic [15:0] POLL_UNIT_CYC  = 16'((POLL_UNIT_NS * CLK_MHZ) / 1000);

    typedef enum logic [3:0] {
        IDLE        = 4'h0,
        RD_STAT     = 4'h1,
        WAIT_VIS    = 4'h3,
        RD_FADDR    = 4'h2,
        RD_FLEN     = 4'h6,
        MOVE_POP    = 4'h7,
        MOVE_WR     = 4'h5,
        WR_DONE     = 4'h4,
        RELEASE     = 4'hc,
        WAIT_RESUME = 4'hd,
        RD_NEXT     = 4'hf,
        POLL_NEXT   = 4'he,
        POLL_STAT   = 4'ha,
        WR_FULL     = 4'hb,
        RD_LINK     = 4'h9,
        NEED        = 4'h8
    } state_t;
endpackage

// *** inc/engine_ifs.sv ***
// engine helper interfaces
interface mem_if;
    logic        start;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        done;
    modport engine (output start, we, addr, wdata, input rdata, done);
    modport master (input start, we, addr, wdata, output rdata, done);
endinterface

interface watch_if;
    logic [7:0] thresh;
    logic       visible;
    logic       burst_ok;
    modport engine  (output thresh, input visible, burst_ok);
    modport watcher (input thresh, output visible, burst_ok);
endinterface

// *** rtl/host_mem_master.sv ***
// single-word host memory master
module host_mem_master
    import upload_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // engine side
    mem_if.master            m,
    // host memory side
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack
);
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        done;
    } mst_t;

    mst_t s;
    mst_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (s.req && mem_ack) begin
            next_s.req = 1'b0;
            next_s.done = 1'b1;
            next_s.rdata = mem_rdata;
        end else if (!s.req && m.start) begin
            next_s.req = 1'b1;
            next_s.we = m.we;
            next_s.addr = m.addr;
            next_s.wdata = m.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign mem_req   = s.req;
    assign mem_we    = s.we;
    assign mem_addr  = s.addr;
    assign mem_wdata = s.wdata;
    assign m.rdata   = s.rdata;
    assign m.done    = s.done;
endmodule

// *** rtl/rx_watch.sv ***
// frame visibility and burst watch
module rx_watch
    import upload_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // engine side
    watch_if.watcher         w,
    // receive fifo state
    input  wire logic [15:0] rx_fifo_bytes,
    input  wire logic [15:0] rx_frame_bytes,
    input  wire logic        rx_frame_end
);
    typedef struct packed {
        logic visible;
        logic burst_ok;
    } wat_t;

    wat_t        s;
    wat_t        next_s;
    logic [15:0] limit;

    always_comb begin
        limit = {3'h0, w.thresh, 5'h00};
        next_s.visible = rx_frame_end || (rx_frame_bytes >= VISIBLE_BYTES); // RULE4
        next_s.burst_ok = rx_frame_end || (rx_fifo_bytes > limit); // RULE13
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign w.visible  = s.visible;
    assign w.burst_ok = s.burst_ok;
endmodule

// *** rtl/upload_engine.sv ***
// receive upload engine walking the descriptor list
// Functional notes
// RULE1: start only with nonzero pointer, not paused
// RULE2: done or full flag set pauses engine
// RULE3: nonzero poll interval re-reads flags instead
// RULE4: frame visible after 64 bytes or end
// RULE5: fragments exhausted sets full, follows link
// RULE6: no next descriptor raises needed, waits
// RULE7: length field tracks upload, final at end
// RULE8: merge frame status, set done, write back
// RULE9: release frame internally, wait for finish
// RULE10: paused mid-frame waits for resume first
// RULE11: fetch link, poll while zero, load pointer
// RULE12: zero pointer without polling means idle
// RULE13: burst only above threshold times 32 bytes
// RULE14: threshold resets to 4; never program zero
// RULE15: pointer cleared by all three resets
// RULE16: descriptors 8-byte aligned, low bits zero
// RULE17: pointer writes ignored while list nonempty
// RULE18: pointer read while polling forces poll; code does so in POLL_STAT only, not in POLL_NEXT or NEED
// RULE19: software pauses before writing the pointer
// RULE20: software writes pointer as one word
// RULE21: status upper bits, length lower bits
// RULE22: paused bit follows pause and resume
// RULE23: needed bit unlatched, cleared by release
// RULE24: fragments filled strictly in list order
//
// The implementer's own choice: strobed register access.
module upload_engine
    import upload_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // receive fifo
    input  wire logic [15:0] rx_fifo_bytes,
    input  wire logic [15:0] rx_frame_bytes,
    input  wire logic        rx_frame_end,
    input  wire logic [6:0]  rx_frame_info,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_data_valid,
    output logic             rx_pop,
    output logic             rx_release,
    input  wire logic        rx_release_done,
    // host memory master
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack
);
    typedef struct packed {
        state_t      state;
        logic [31:0] ptr;
        logic [31:0] prev;
        logic [7:0]  thresh;
        logic [7:0]  poll;
        logic        paused;
        logic        needed;
        logic        complete;
        logic        mid_frame;
        logic [14:0] len;
        logic [7:0]  frag_idx;
        logic [31:0] frag_addr;
        logic [15:0] frag_left;
        logic        frag_last;
        logic [15:0] timer;
        logic        mem_start;
        logic        mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic        rx_pop;
        logic        rx_release;
        logic [31:0] rdata;
    } eng_t;

    eng_t        s;
    eng_t        next_s;
    logic        poll_kick;
    logic        resume;
    logic        up_reset;
    logic [31:0] status_now;
    logic [31:0] link;
    logic [15:0] poll_load;

    mem_if   m ();
    watch_if w ();

    host_mem_master u_master (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .m         (m),
        .mem_req   (mem_req),
        .mem_we    (mem_we),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_rdata (mem_rdata),
        .mem_ack   (mem_ack)
    );

    rx_watch u_watch (
        .clk            (clk),
        .rst_b          (rst_b),
        .ce             (ce),
        .w              (w),
        .rx_fifo_bytes  (rx_fifo_bytes),
        .rx_frame_bytes (rx_frame_bytes),
        .rx_frame_end   (rx_frame_end)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // fragment entry word address
    function automatic logic [31:0] frag_entry(input logic [31:0] base,
                                               input logic [7:0]  idx,
                                               input logic [31:0] word);
        frag_entry = base + DESC_FRAG + {21'h0, idx, 3'h0} + word;
    endfunction

    always_comb begin
        next_s = s;
        next_s.mem_start = 1'b0;
        next_s.rx_pop = 1'b0;
        next_s.rx_release = 1'b0;
        poll_kick = rd && hit(addr, OFS_PTR);
        resume = wr && hit(addr, OFS_CMD) && wdata[CMD_RESUME];
        up_reset = wr && hit(addr, OFS_CMD) && (wdata[CMD_UP_RST] || wdata[CMD_ALL_RST]);
        link = m.rdata & PTR_MASK;
        poll_load = 16'(s.poll) * POLL_UNIT_CYC;
        status_now = '0;
        status_now[LEN_W-1:0] = rx_frame_end ? rx_frame_bytes[LEN_W-1:0] : s.len; // RULE7
        status_now[ST_PAUSED] = s.paused; // RULE22
        status_now[ST_PAUSED+1 +: INFO_W] = rx_frame_info; // RULE21
        status_now[ST_COMPLETE] = s.complete;
        status_now[ST_NEEDED] = s.needed;

        // register access
        if (rd) begin
            unique case (addr)
                OFS_STATUS: next_s.rdata = status_now; // RULE21
                OFS_PTR:    next_s.rdata = s.ptr;
                OFS_THRESH: next_s.rdata = {24'h0, s.thresh};
                OFS_POLL:   next_s.rdata = {24'h0, s.poll};
                default:    next_s.rdata = '0;
            endcase
        end
        if (wr) begin
            if (hit(addr, OFS_THRESH)) begin
                next_s.thresh = wdata[7:0];
            end
            if (hit(addr, OFS_POLL)) begin
                next_s.poll = wdata[7:0];
            end
            if (hit(addr, OFS_PTR) && s.ptr == '0) begin // RULE17
                next_s.ptr = wdata & PTR_MASK; // RULE16
            end
            if (hit(addr, OFS_CMD) && wdata[CMD_PAUSE]) begin
                next_s.paused = 1'b1; // RULE22
            end
            if (resume) begin
                next_s.paused = 1'b0; // RULE22
            end
        end

        unique case (s.state)
            IDLE: begin
                if (s.ptr != '0 && !s.paused) begin // RULE1 RULE12
                    next_s.state = RD_STAT;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = s.ptr + DESC_STAT;
                end
            end
            RD_STAT: begin
                if (m.done) begin
                    if (m.rdata[ST_COMPLETE] || m.rdata[ST_FULL]) begin
                        next_s.needed = s.mid_frame; // RULE6
                        if (s.poll != '0) begin
                            next_s.state = POLL_STAT; // RULE3
                            next_s.timer = poll_load;
                        end else begin
                            next_s.paused = 1'b1; // RULE2
                            next_s.state = IDLE;
                        end
                    end else if (s.mid_frame) begin
                        next_s.needed = 1'b0;
                        next_s.frag_idx = '0;
                        next_s.state = RD_FADDR;
                        next_s.mem_start = 1'b1;
                        next_s.mem_we = 1'b0;
                        next_s.mem_addr = frag_entry(s.ptr, 8'h00, 32'h0);
                    end else begin
                        next_s.state = WAIT_VIS;
                    end
                end
            end
            POLL_STAT: begin
                if (s.paused) begin
                    next_s.state = IDLE;
                end else if (s.timer == '0 || poll_kick) begin // RULE18
                    next_s.state = RD_STAT; // RULE3
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = s.ptr + DESC_STAT;
                end else begin
                    next_s.timer = s.timer - 16'h0001;
                end
            end
            WAIT_VIS: begin
                if (w.visible) begin // RULE4
                    next_s.mid_frame = 1'b1;
                    next_s.complete = 1'b0;
                    next_s.len = '0;
                    next_s.frag_idx = '0;
                    next_s.state = RD_FADDR;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = frag_entry(s.ptr, 8'h00, 32'h0);
                end
            end
            RD_FADDR: begin
                if (m.done) begin
                    next_s.frag_addr = m.rdata;
                    next_s.state = RD_FLEN;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = frag_entry(s.ptr, s.frag_idx, WORD_BYTES);
                end
            end
            RD_FLEN: begin
                if (m.done) begin
                    next_s.frag_left = m.rdata[FRAG_LEN_W-1:0];
                    next_s.frag_last = m.rdata[FRAG_LAST];
                    next_s.state = MOVE_POP;
                end
            end
            MOVE_POP: begin
                if (rx_frame_end && !rx_data_valid) begin
                    next_s.complete = 1'b1; // RULE8
                    next_s.state = WR_DONE;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b1;
                    next_s.mem_addr = s.ptr + DESC_STAT;
                    next_s.mem_wdata = status_now | (32'h1 << ST_COMPLETE); // RULE8
                end else if (s.frag_left < WORD_BYTES) begin
                    if (s.frag_last) begin
                        next_s.state = WR_FULL; // RULE5
                        next_s.mem_start = 1'b1;
                        next_s.mem_we = 1'b1;
                        next_s.mem_addr = s.ptr + DESC_STAT;
                        next_s.mem_wdata = status_now | (32'h1 << ST_FULL);
                    end else begin
                        next_s.frag_idx = s.frag_idx + 8'h01; // RULE24
                        next_s.state = RD_FADDR;
                        next_s.mem_start = 1'b1;
                        next_s.mem_we = 1'b0;
                        next_s.mem_addr = frag_entry(s.ptr, s.frag_idx + 8'h01, 32'h0);
                    end
                end else if (rx_data_valid && w.burst_ok) begin // RULE13
                    next_s.rx_pop = 1'b1;
                    next_s.state = MOVE_WR;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b1;
                    next_s.mem_addr = s.frag_addr;
                    next_s.mem_wdata = rx_data;
                    next_s.frag_addr = s.frag_addr + 32'(WORD_BYTES);
                    next_s.frag_left = s.frag_left - WORD_BYTES;
                    next_s.len = s.len + WORD_BYTES[LEN_W-1:0]; // RULE7
                end
            end
            MOVE_WR: begin
                if (m.done) begin
                    next_s.state = MOVE_POP;
                end
            end
            WR_FULL: begin
                if (m.done) begin
                    next_s.prev = s.ptr;
                    next_s.state = RD_LINK;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = s.ptr + DESC_LINK;
                end
            end
            RD_LINK: begin
                if (m.done) begin
                    next_s.ptr = link;
                    if (link != '0) begin
                        next_s.state = RD_STAT; // RULE5
                        next_s.mem_start = 1'b1;
                        next_s.mem_we = 1'b0;
                        next_s.mem_addr = link + DESC_STAT;
                    end else begin
                        next_s.needed = 1'b1; // RULE6
                        next_s.timer = poll_load;
                        next_s.state = NEED;
                    end
                end
            end
            NEED: begin
                if (resume && s.ptr != '0) begin // RULE6
                    next_s.state = RD_STAT;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = s.ptr + DESC_STAT;
                end else if (s.poll != '0 && s.timer == '0) begin
                    next_s.state = RD_LINK;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = s.prev + DESC_LINK;
                end else if (s.timer != '0) begin
                    next_s.timer = s.timer - 16'h0001;
                end
            end
            WR_DONE: begin
                if (m.done) begin
                    next_s.rx_release = 1'b1; // RULE9
                    next_s.state = RELEASE;
                end
            end
            RELEASE: begin
                if (rx_release_done) begin
                    next_s.needed = 1'b0; // RULE23
                    next_s.state = WAIT_RESUME; // RULE9
                end
            end
            WAIT_RESUME: begin
                if (!s.paused) begin // RULE10
                    next_s.state = RD_NEXT;
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = s.ptr + DESC_LINK;
                end
            end
            RD_NEXT: begin
                if (m.done) begin
                    if (link == '0 && s.poll != '0) begin
                        next_s.timer = poll_load; // RULE11
                        next_s.state = POLL_NEXT;
                    end else begin
                        next_s.ptr = link; // RULE11 RULE12
                        next_s.mid_frame = 1'b0;
                        next_s.state = IDLE;
                    end
                end
            end
            POLL_NEXT: begin
                if (s.timer == '0) begin
                    next_s.state = RD_NEXT; // RULE11
                    next_s.mem_start = 1'b1;
                    next_s.mem_we = 1'b0;
                    next_s.mem_addr = s.ptr + DESC_LINK;
                end else begin
                    next_s.timer = s.timer - 16'h0001;
                end
            end
        endcase

        if (up_reset) begin
            next_s.ptr = '0; // RULE15
            next_s.state = IDLE;
            next_s.paused = 1'b0;
            next_s.needed = 1'b0;
            next_s.mid_frame = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0; // RULE15
            s.state <= IDLE;
            s.thresh <= THRESH_RST; // RULE14
            s.poll <= POLL_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign m.start    = s.mem_start;
    assign m.we       = s.mem_we;
    assign m.addr     = s.mem_addr;
    assign m.wdata    = s.mem_wdata;
    assign w.thresh   = s.thresh;
    assign rdata      = s.rdata;
    assign rx_pop     = s.rx_pop;
    assign rx_release = s.rx_release;
endmodule

// *** testbench/upload_engine_sva.sv ***
// upload engine assertions
module upload_engine_sva
    import upload_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [31:0] rdata,
    // receive fifo
    input  wire logic [15:0] rx_fifo_bytes,
    input  wire logic [15:0] rx_frame_bytes,
    input  wire logic        rx_frame_end,
    input  wire logic        rx_pop,
    input  wire logic        rx_release,
    input  wire logic        rx_release_done,
    // host memory
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] thr;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) thr <= THRESH_RST;
        else if (ce && wr && addr == OFS_THRESH) thr <= wdata[7:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence rd_of(logic [7:0] a); rd && addr == a; endsequence
    sequence pause_wr; wr && addr == OFS_CMD && wdata[1:0] == 2'b01; endsequence
    sequence soft_rst; wr && addr == OFS_CMD && wdata[CMD_UP_RST]; endsequence
    thresh_read_a: assert property (rd_of(OFS_THRESH) |=> rdata == {24'h0, thr})
        else $error("threshold readback wrong");
    ptr_reset_a: assert property (soft_rst ##[1:3] rd_of(OFS_PTR) |=> rdata == 32'h0)
        else $error("pointer not cleared");
    pause_flag_a: assert property (pause_wr ##[1:3] rd_of(OFS_STATUS) |=> rdata[ST_PAUSED])
        else $error("paused bit missing");
    frame_visible_a: assert property (rx_pop |-> rx_frame_bytes >= VISIBLE_BYTES || rx_frame_end)
        else $error("pop before frame visible");
    burst_gate_a: assert property (rx_pop |-> rx_fifo_bytes > {3'h0, thr, 5'h0} || rx_frame_end)
        else $error("pop below threshold");
    done_entry_a: assert property (mem_req && mem_we && mem_wdata[ST_COMPLETE] |-> mem_addr[2:0] == 3'h4)
        else $error("done status misplaced");
    full_entry_a: assert property (mem_req && mem_we && mem_wdata[ST_FULL] |-> mem_addr[2:0] == 3'h4)
        else $error("full status misplaced");
    release_wait_a: assert property (rx_release |=> !mem_req [*3])
        else $error("request during release");
endmodule

bind upload_engine upload_engine_sva upload_engine_sva_i (.*);

// *** testbench/mem_model.sv ***
// host memory model, alternating ack delay
module mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // request side
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic [31:0]      mem_rdata,
    output logic             mem_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [64];
    logic [3:0]  cnt;
    logic [3:0]  dly;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            dly <= 4'h0;
            mem_rdata <= 32'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                cnt <= cnt + 4'h1;
                if (cnt >= dly) begin
                    mem_ack <= 1'b1;
                    cnt <= 4'h0;
                    dly <= dly ^ 4'h5;
                    if (mem_we) mem[mem_addr[7:2]] <= mem_wdata;
                    else mem_rdata <= mem[mem_addr[7:2]];
                end
            end
        end
    end
endmodule

// *** testbench/upload_engine_test.sv ***
// self-checking bench for the upload engine
module upload_engine_test
    import upload_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_b, ce, wr, rd, rx_frame_end, rx_data_valid, rx_pop;
    logic        rx_release, rx_release_done, mem_req, mem_we, mem_ack;
    logic [7:0]  addr;
    logic [6:0]  rx_frame_info;
    logic [15:0] rx_fifo_bytes, rx_frame_bytes, idx, nw;
    logic [31:0] wdata, rdata, rx_data, mem_addr, mem_wdata, mem_rdata;
    int          err_count, total_checks;
    assign rx_data = {16'h0c00, idx};
    assign rx_data_valid = idx < nw;
    assign rx_fifo_bytes = (nw - idx) << 2;
    upload_engine upload_engine_i (.*);
    mem_model mem_model_i (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // fifo stand-in: pops advance, release empties it
    always @(posedge clk) begin
        rx_release_done <= rx_release;
        if (rx_pop) idx <= idx + 16'h1;
        if (rx_release) begin
            nw <= 16'h0;
            idx <= 16'h0;
            rx_frame_end <= 1'b0;
            rx_frame_bytes <= 16'h0;
        end
    end
    task automatic stop_test();
        if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m = 32'hffff_ffff);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata & m, e);
    endtask
    initial begin
        int i;
        rst_b = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h0; wdata = 32'h0;
        rx_frame_end = 1'b0; rx_frame_bytes = 16'h0; rx_frame_info = 7'h15;
        idx = 16'h0; nw = 16'h0; err_count = 0; total_checks = 0;
        for (i = 0; i < 64; i++) mem_model_i.mem[i] = 32'h0;
        mem_model_i.mem[4] = 32'h30;
        mem_model_i.mem[6] = 32'h80;
        mem_model_i.mem[7] = 32'h8000_0008;
        mem_model_i.mem[14] = 32'ha0;
        mem_model_i.mem[15] = 32'h8000_0040;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(OFS_THRESH, 32'h4);
        rd_reg(OFS_PTR, 32'h0);
        rd_reg(8'h20, 32'h0);
        wr_reg(OFS_THRESH, 32'h1);
        rd_reg(OFS_THRESH, 32'h1);
        nw <= 16'h3;
        rx_frame_bytes <= 16'hc;
        wr_reg(OFS_CMD, 32'h1);
        wr_reg(OFS_PTR, 32'h13);
        wr_reg(OFS_CMD, 32'h2);
        wr_reg(OFS_PTR, 32'h50);
        rd_reg(OFS_PTR, 32'h10);
        repeat (30) @(posedge clk);
        chk({16'h0, idx}, 32'h0);
        rx_frame_end <= 1'b1;
        for (i = 0; i < 3000 && !mem_model_i.mem[13][ST_COMPLETE]; i++) @(posedge clk);
        if (i == 3000) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
        chk(mem_model_i.mem[5] & 32'h0200_0000, 32'h0200_0000);
        chk(mem_model_i.mem[13], 32'h0095_000c);
        chk(mem_model_i.mem[32], 32'h0c00_0000);
        chk(mem_model_i.mem[33], 32'h0c00_0001);
        chk(mem_model_i.mem[40], 32'h0c00_0002);
        repeat (20) @(posedge clk);
        rd_reg(OFS_PTR, 32'h0);
        wr_reg(OFS_CMD, 32'h1);
        wr_reg(OFS_PTR, 32'h10);
        wr_reg(OFS_CMD, 32'h2);
        repeat (20) @(posedge clk);
        rd_reg(OFS_STATUS, 32'h0000_8000, 32'h0000_8000);
        mem_model_i.mem[5] = 32'h0;
        wr_reg(OFS_CMD, 32'h2);
        repeat (20) @(posedge clk);
        rd_reg(OFS_STATUS, 32'h0, 32'h0000_8000);
        wr_reg(OFS_CMD, 32'h4);
        rd_reg(OFS_PTR, 32'h0);
        wr_reg(OFS_CMD, 32'h1);
        rd_reg(OFS_STATUS, 32'h0000_8000, 32'h0000_8000);
        stop_test();
    end
endmodule
